// [design/frame_limits_pkg.sv]
package frame_limits_pkg;

	// register map: byte addresses are the register indices times four
	localparam logic [7:0] ctrl_index     = 8'h1b;
	localparam logic [7:0] settings_index = 8'h1c;
	localparam logic [7:0] status_index   = 8'h1d;
	localparam logic [7:0] mode_index     = 8'h1e;
	localparam logic [9:0] ctrl_addr      = {ctrl_index, 2'b00};
	localparam logic [9:0] settings_addr  = {settings_index, 2'b00};
	localparam logic [9:0] status_addr    = {status_index, 2'b00};
	localparam logic [9:0] mode_addr      = {mode_index, 2'b00};

	localparam logic [7:0] ctrl_reset     = 8'h00;
	localparam logic [7:0] settings_reset = 8'h62;
	localparam logic [7:0] mode_reset     = 8'h00;

	// field positions, rx_length_slot_control
	localparam int wait_sel_bit   = 7;
	localparam int short_slot_bit = 6;
	localparam int max_len_lsb    = 0;
	// field positions, target_card_settings
	localparam int sens_lsb       = 5;
	localparam int tau_lsb        = 3;
	localparam int halt_bit       = 2;
	localparam int resp_ext_lsb   = 0;
	// field positions, mode register
	localparam int sync_det_bit   = 0;
	localparam int active_bit     = 1;
	localparam int min_len_lsb    = 2;

	localparam logic [8:0] len_zero_max   = 9'h100;
	localparam logic [7:0] req_code_halt  = 8'h52;
	localparam logic [3:0] base_resp_bits = 4'h7;

	// timing: data bit period at each rate, in nanoseconds
	localparam int clock_ns   = 50;
	localparam int bit106_ns  = 9440;
	localparam int bit212_ns  = 4720;
	localparam int bit424_ns  = 2360;
	localparam int slot212_bits = 128;

	typedef enum logic [1:0] {
		rate_106 = 2'b00,
		rate_212 = 2'b01,
		rate_424 = 2'b10
	} rate_t;

	typedef struct packed {
		logic       start;
		logic       done;
		logic [8:0] length;
		logic       is_request;
		logic [7:0] req_code;
		logic       valid_cmd;
	} rx_frame_t;

	typedef struct packed {
		logic       accept;
		logic       drop;
	} rx_verdict_t;

endpackage

// [design/contactless_frame_limits_timing.sv]
`timescale 1ns/1ps
// Functional notes
// - with wait_until_selected set, anticollision ends only on a valid command after a finished select.
// - while wait_until_selected is set, active communication mode is blocked.
// - at 424 kbit passive, short_slot_select picks half the 212 kbit slot, else the full 212 kbit slot.
// - a packet longer than four times max_length_limit is ignored.
// - a max_length_limit of zero means a 256 byte limit.
// - at 106 kbit with sync_detect_enable clear the length checks are skipped.
// - pulse_decoder_sensitivity comes from bits 7 to 5 of the settings register.
// - pulse_decoder_time_constant comes from bits 4 to 3 of the settings register.
// - while card_halt_flag is set at 106 kbit card mode, only request code 52h is accepted.
// - card_halt_flag is set by the host or the protocol engine, and cleared by an rf reset.
// - the least response time is 7 data bits plus min_response_extension.
// - a transmit asked early waits until the least response time is over.
// - a transmit asked late starts at once when bit phase is aligned.
// - a packet shorter than four times min_length_limit is ignored, except 106 kbit without sync.
module contactless_frame_limits_timing
	import frame_limits_pkg::*;
#(
	parameter int addr_w = 10
)(
	input  wire logic              clock,
	input  wire logic              rst_n,
	input  wire logic [addr_w-1:0] avs_address,
	input  wire logic              avs_read,
	input  wire logic              avs_write,
	input  wire logic [31:0]       avs_writedata,
	output logic      [31:0]       avs_readdata,
	output logic                   avs_waitrequest,
	input  wire rate_t             rate,
	input  wire logic              card_mode,
	input  wire rx_frame_t         rx_frame,
	output rx_verdict_t            rx_verdict,
	input  wire logic              halt_set,
	input  wire logic              rf_reset,
	input  wire logic              select_done,
	input  wire logic              anticoll_active,
	output logic                   anticoll_end,
	input  wire logic              tx_request,
	input  wire logic              bit_phase_ok,
	output logic                   tx_start,
	output logic                   active_mode_en,
	output logic      [7:0]        slot_bits,
	output logic      [2:0]        pulse_decoder_sensitivity,
	output logic      [1:0]        pulse_decoder_time_constant
);

	////////////////////////////////////////////////////////////////////////
	// reset release
	// asserted at once, released on a clock edge so that no flop leaves
	// reset one cycle apart from its neighbours
	logic [1:0] rst_sync_ff;
	logic       rst_i_n;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rst_sync_ff <= 2'b00;
		end else begin
			rst_sync_ff <= {rst_sync_ff[0], 1'b1};
		end
	end
	assign rst_i_n = rst_sync_ff[1];

	////////////////////////////////////////////////////////////////////////
	// register bus: one wait cycle per access, then the answer
	logic [7:0]  ctrl_ff, nxt_ctrl;
	logic [7:0]  settings_ff, nxt_settings;
	logic [7:0]  mode_ff, nxt_mode;
	logic        ack_ff, nxt_ack;
	logic [31:0] rdata_ff, nxt_rdata;
	logic [1:0]  stat_ff, nxt_stat;
	logic        wr_ok;
	logic        halt_wr;

	assign wr_ok = avs_write && ack_ff;
	assign avs_waitrequest = (avs_read || avs_write) && !ack_ff;
	assign avs_readdata = rdata_ff;

	assign pulse_decoder_sensitivity   = settings_ff[sens_lsb +: 3];
	assign pulse_decoder_time_constant = settings_ff[tau_lsb +: 2];

	always_comb begin
		nxt_ctrl     = ctrl_ff;
		nxt_settings = settings_ff;
		nxt_mode     = mode_ff;
		nxt_ack      = (avs_read || avs_write) && !ack_ff;
		nxt_rdata    = rdata_ff;
		halt_wr      = 1'b0;
		// unmapped addresses take writes silently and read as zero
		if (wr_ok) begin
			unique case (avs_address[9:0])
				ctrl_addr:     nxt_ctrl = avs_writedata[7:0];
				settings_addr: begin
					nxt_settings = avs_writedata[7:0];
					halt_wr = avs_writedata[halt_bit];
				end
				mode_addr:     nxt_mode = avs_writedata[7:0];
				default:       ;
			endcase
		end
		// set beats clear: host write of halt 0 loses to an engine set
		if (halt_set || halt_wr) begin
			nxt_settings[halt_bit] = 1'b1;
		end else if (rf_reset) begin
			nxt_settings[halt_bit] = 1'b0;
		end
		// the read word is captured on the wait cycle, so it is settled
		// at the edge on which the master takes it
		if (avs_read && !ack_ff) begin
			unique case (avs_address[9:0])
				ctrl_addr:     nxt_rdata = {24'h0, ctrl_ff};
				settings_addr: nxt_rdata = {24'h0, settings_ff};
				status_addr:   nxt_rdata = {30'h0, stat_ff};
				mode_addr:     nxt_rdata = {24'h0, mode_ff};
				default:       nxt_rdata = 32'h0;
			endcase
		end
	end

	always_ff @(posedge clock or negedge rst_i_n) begin
		if (!rst_i_n) begin
			ctrl_ff     <= ctrl_reset;
			settings_ff <= settings_reset;
			mode_ff     <= mode_reset;
			ack_ff      <= 1'b0;
			rdata_ff    <= 32'h0;
		end else begin
			ctrl_ff     <= nxt_ctrl;
			settings_ff <= nxt_settings;
			mode_ff     <= nxt_mode;
			ack_ff      <= nxt_ack;
			rdata_ff    <= nxt_rdata;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// mode and slot
	// slot length is counted in 212 kbit bit times
	logic wait_sel;
	assign wait_sel = ctrl_ff[wait_sel_bit];
	assign active_mode_en = mode_ff[active_bit] && !wait_sel;

	always_comb begin
		slot_bits = 8'(slot212_bits);
		if (rate == rate_424 && ctrl_ff[short_slot_bit]) begin
			slot_bits = 8'(slot212_bits / 2);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// packet filter, verdict registered on frame end
	// lengths are in bytes; both limits are multiples of four
	logic [8:0] max_len, min_len;
	logic       skip_len, len_bad, halt_bad;
	logic [5:0] max_field;

	assign max_field = ctrl_ff[max_len_lsb +: 6];
	assign max_len = (max_field == 6'h00) ? len_zero_max
	                 : {1'b0, max_field, 2'b00};
	assign min_len = {1'b0, mode_ff[min_len_lsb +: 6], 2'b00};
	assign skip_len = (rate == rate_106) && !mode_ff[sync_det_bit];
	assign len_bad = !skip_len && ((rx_frame.length > max_len)
	                 || (rx_frame.length < min_len));
	assign halt_bad = settings_ff[halt_bit] && card_mode
	                  && rate == rate_106 && rx_frame.is_request
	                  && rx_frame.req_code != req_code_halt;

	rx_verdict_t verdict_ff, nxt_verdict;
	always_comb begin
		nxt_verdict.accept = rx_frame.done && !len_bad && !halt_bad;
		// dropped frames give no data and need no recovery step
		nxt_verdict.drop = rx_frame.done && (len_bad || halt_bad);
	end
	assign rx_verdict = verdict_ff;

	////////////////////////////////////////////////////////////////////////
	// anticollision end, response timer
	localparam int b106_cyc = bit106_ns / clock_ns;
	localparam int b212_cyc = bit212_ns / clock_ns;
	localparam int b424_cyc = bit424_ns / clock_ns;

	logic        selected_ff, nxt_selected;
	logic        end_ff, nxt_end;
	logic [7:0]  bitcyc_ff, nxt_bitcyc;
	logic [3:0]  bits_ff, nxt_bits;
	logic        pend_ff, nxt_pend;
	logic        start_ff, nxt_start;
	logic [7:0]  bit_len;
	logic [3:0]  need_bits;
	logic        elapsed;

	always_comb begin
		unique case (rate)
			rate_212: bit_len = 8'(b212_cyc);
			rate_424: bit_len = 8'(b424_cyc);
			default:  bit_len = 8'(b106_cyc);
		endcase
	end
	assign need_bits = base_resp_bits
	                   + {2'b00, settings_ff[resp_ext_lsb +: 2]};
	assign elapsed = bits_ff >= need_bits;

	// anticollision: a select only counts while the command runs, and is
	// forgotten as soon as the command ends
	always_comb begin
		nxt_selected = selected_ff;
		nxt_end = 1'b0;
		if (!anticoll_active) begin
			nxt_selected = 1'b0;
		end else if (select_done) begin
			nxt_selected = 1'b1;
		end
		if (anticoll_active && nxt_verdict.accept && rx_frame.valid_cmd) begin
			nxt_end = !wait_sel || selected_ff;
		end
	end

	always_ff @(posedge clock or negedge rst_i_n) begin
		if (!rst_i_n) begin
			selected_ff <= 1'b0;
			end_ff      <= 1'b0;
		end else begin
			selected_ff <= nxt_selected;
			end_ff      <= nxt_end;
		end
	end
	assign anticoll_end = end_ff;

	// response timer: restarts on every frame end and stops once elapsed,
	// so the bit counter cannot wrap back under the limit
	always_comb begin
		nxt_bitcyc = bitcyc_ff;
		nxt_bits   = bits_ff;
		if (rx_frame.done) begin
			nxt_bitcyc = 8'h00;
			nxt_bits   = 4'h0;
		end else if (!elapsed) begin
			if (bitcyc_ff + 8'h01 >= bit_len) begin
				nxt_bitcyc = 8'h00;
				nxt_bits   = bits_ff + 4'h1;
			end else begin
				nxt_bitcyc = bitcyc_ff + 8'h01;
			end
		end
	end

	always_ff @(posedge clock or negedge rst_i_n) begin
		if (!rst_i_n) begin
			bitcyc_ff <= 8'h00;
			bits_ff   <= 4'h0;
		end else begin
			bitcyc_ff <= nxt_bitcyc;
			bits_ff   <= nxt_bits;
		end
	end

	// transmit: a request is held until the timer and the bit phase allow it
	always_comb begin
		nxt_pend  = pend_ff || tx_request;
		nxt_start = 1'b0;
		if (nxt_pend && elapsed && bit_phase_ok) begin
			nxt_start = 1'b1;
			nxt_pend  = 1'b0;
		end
	end

	always_ff @(posedge clock or negedge rst_i_n) begin
		if (!rst_i_n) begin
			pend_ff  <= 1'b0;
			start_ff <= 1'b0;
		end else begin
			pend_ff  <= nxt_pend;
			start_ff <= nxt_start;
		end
	end
	assign tx_start = start_ff;

	// status lags the timer by one cycle; it is meant for software only
	always_comb nxt_stat = {pend_ff, elapsed};
	always_ff @(posedge clock or negedge rst_i_n) begin
		if (!rst_i_n) begin
			stat_ff <= 2'b00;
		end else begin
			stat_ff <= nxt_stat;
		end
	end

	// verdict pulses stand for the one cycle after the frame end
	always_ff @(posedge clock or negedge rst_i_n) begin
		if (!rst_i_n) begin
			verdict_ff <= '0;
		end else begin
			verdict_ff <= nxt_verdict;
		end
	end
endmodule

// [sim/rf_peer_model.sv]
`timescale 1ns/1ps
module rf_peer_model
	import frame_limits_pkg::*;
(
	input  wire logic       clock,
	input  wire logic       send,
	input  wire logic [8:0] len,
	input  wire logic [7:0] code,
	input  wire logic       is_req,
	output rx_frame_t       rx_frame
);
	logic pend_ff = 1'b0;
	initial rx_frame = '0;
	////////////////////////////////////////
	// fields carry nothing outside done, so they toggle there to expose a
	// receiver that samples them at the wrong moment
	always @(posedge clock) begin
		pend_ff <= send;
		rx_frame.start <= send;
		rx_frame.done <= pend_ff;
		rx_frame.length <= pend_ff ? len : ~rx_frame.length;
		rx_frame.req_code <= pend_ff ? code : ~rx_frame.req_code;
		rx_frame.is_request <= pend_ff ? is_req : ~rx_frame.is_request;
		rx_frame.valid_cmd <= pend_ff | ~rx_frame.valid_cmd;
	end
endmodule

// [sim/frame_limits_assertions.sv]
`timescale 1ns/1ps
module frame_limits_assertions
	import frame_limits_pkg::*;
#(
	parameter int addr_w = 10
)(
	input wire logic              clock,
	input wire logic              rst_n,
	input wire logic [addr_w-1:0] avs_address,
	input wire logic              avs_read,
	input wire logic              avs_write,
	input wire logic [31:0]       avs_readdata,
	input wire logic              avs_waitrequest,
	input wire rate_t             rate,
	input wire rx_frame_t         rx_frame,
	input wire rx_verdict_t       rx_verdict,
	input wire logic              anticoll_active,
	input wire logic              anticoll_end,
	input wire logic              bit_phase_ok,
	input wire logic              tx_start,
	input wire logic [7:0]        slot_bits
);
	logic ack;
	logic mapped;
	assign ack = avs_read && !avs_waitrequest;
	assign mapped = avs_address inside {ctrl_addr, settings_addr,
		status_addr, mode_addr};
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_n);
	////////////////////////////////////////
	a_verdict_each: assert property (rx_frame.done |=>
		rx_verdict.accept ^ rx_verdict.drop) else $error("no verdict");
	a_verdict_cause: assert property ((rx_verdict.accept ||
		rx_verdict.drop) |-> $past(rx_frame.done)) else $error("stray verdict");
	a_slot_legal: assert property (slot_bits == 8'h80 ||
		(slot_bits == 8'h40 && rate == rate_424)) else $error("bad slot");
	a_tx_not_early: assert property (rx_frame.done |->
		##2 !tx_start [*8]) else $error("tx too early");
	a_tx_phase: assert property (tx_start |-> $past(bit_phase_ok))
		else $error("tx without phase");
	a_end_cause: assert property (anticoll_end |->
		$past(anticoll_active)) else $error("stray anticollision end");
	a_wait_once: assert property ((avs_read || avs_write) &&
		avs_waitrequest |=> !avs_waitrequest) else $error("wait too long");
	a_read_clean: assert property (ack |-> avs_readdata[31:8] == 24'h0 &&
		(mapped || avs_readdata[7:0] == 8'h00)) else $error("bad read data");
endmodule
bind contactless_frame_limits_timing frame_limits_assertions #(
	.addr_w(addr_w)) u_chk (.clock(clock), .rst_n(rst_n),
	.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
	.rate(rate), .rx_frame(rx_frame), .rx_verdict(rx_verdict),
	.anticoll_active(anticoll_active), .anticoll_end(anticoll_end),
	.bit_phase_ok(bit_phase_ok), .tx_start(tx_start), .slot_bits(slot_bits));

// [sim/contactless_frame_limits_timing_tb_top.sv]
`timescale 1ns/1ps
module contactless_frame_limits_timing_tb_top
	import frame_limits_pkg::*;
;
	typedef struct {rate_t r; logic s; logic [5:0] mx, mn; logic [8:0] ln;
		logic a;} row_t;
	logic        clock = 1'b0, rst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
	logic        card_mode = 1'b0, anticoll_active = 1'b0, send = 1'b0;
	logic        bit_phase_ok = 1'b1, is_req = 1'b0, got = 1'b0;
	logic        avs_waitrequest, anticoll_end, tx_start, active_mode_en;
	logic [3:0]  pls = 4'h0;
	logic [9:0]  avs_address = 10'h000;
	logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
	logic [8:0]  len = 9'h000;
	logic [7:0]  code = 8'h00, slot_bits;
	logic [2:0]  sens;
	logic [1:0]  tau;
	rate_t       rate = rate_106;
	rx_frame_t   rx_frame;
	rx_verdict_t rx_verdict;
	int          n_fail = 0, n_compared = 0, cyc = 0, t_done = 0, t_start = 0;
	int          n_end = 0, n;
	row_t        rows [9] = '{
		'{rate_212, 1'h0, 6'h00, 6'h00, 9'h100, 1'h1},
		'{rate_212, 1'h0, 6'h00, 6'h00, 9'h101, 1'h0},
		'{rate_212, 1'h0, 6'h05, 6'h00, 9'h014, 1'h1},
		'{rate_212, 1'h0, 6'h05, 6'h00, 9'h015, 1'h0},
		'{rate_106, 1'h0, 6'h05, 6'h00, 9'h015, 1'h1},
		'{rate_106, 1'h1, 6'h05, 6'h00, 9'h015, 1'h0},
		'{rate_424, 1'h1, 6'h00, 6'h03, 9'h00b, 1'h0},
		'{rate_424, 1'h1, 6'h00, 6'h03, 9'h00c, 1'h1},
		'{rate_106, 1'h0, 6'h00, 6'h03, 9'h00b, 1'h1}};
	rf_peer_model peer (.clock(clock), .send(send), .len(len), .code(code),
		.is_req(is_req), .rx_frame(rx_frame));
	contactless_frame_limits_timing #(.addr_w(10)) dut (.clock(clock),
		.rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.rate(rate), .card_mode(card_mode), .rx_frame(rx_frame),
		.rx_verdict(rx_verdict), .halt_set(pls[0]), .rf_reset(pls[1]),
		.select_done(pls[2]), .anticoll_active(anticoll_active),
		.anticoll_end(anticoll_end), .tx_request(pls[3]),
		.bit_phase_ok(bit_phase_ok), .tx_start(tx_start),
		.active_mode_en(active_mode_en), .slot_bits(slot_bits),
		.pulse_decoder_sensitivity(sens), .pulse_decoder_time_constant(tau));
	always #25 clock = ~clock;
	////////////////////////////////////////
	// event times in cycles, so response gaps need no waiting loop of their own
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (rx_frame.done === 1'b1)
			t_done <= cyc;
		if (tx_start === 1'b1)
			t_start <= cyc;
		if (anticoll_end === 1'b1)
			n_end <= n_end + 1;
	end
	task automatic chk(input logic ok, input string m);
		n_compared++;
		if (ok !== 1'b1) begin
			n_fail++;
			$display("[ERR] %0t %s", $time, m);
		end
	endtask
	task automatic conclude;
		$display("compared %0d, failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// the extra edge at the end keeps back-to-back requests from
	// assigning read or write twice in one time step
	task automatic bus(input logic we, input logic [9:0] a, input logic [7:0] d);
		int i;
		avs_address <= a;
		avs_write <= we;
		avs_read <= !we;
		avs_writedata <= {24'h000000, d};
		for (i = 0; i < 20; i++) begin
			@(posedge clock);
			if (avs_waitrequest === 1'b0)
				break;
		end
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge clock);
		if (i == 20) begin
			chk(1'b0, "bus hang");
			conclude;
		end
	endtask
	task automatic frame(input logic [8:0] l, input logic [7:0] c,
			input logic r, input logic acc);
		len <= l;
		code <= c;
		is_req <= r;
		send <= 1'b1;
		@(posedge clock);
		send <= 1'b0;
		repeat (3) @(posedge clock);
		chk(rx_verdict === rx_verdict_t'({acc, !acc}), "verdict");
	endtask
	task automatic pulse(input int b);
		pls[b] <= 1'b1;
		@(posedge clock);
		pls <= 4'h0;
	endtask
	task automatic wait_start(input int lim);
		int s;
		s = t_start;
		got = 1'b0;
		for (int i = 0; i < lim && !got; i++) begin
			@(posedge clock);
			got = (t_start != s);
		end
	endtask
	initial begin
		repeat (10) @(posedge clock);
		rst_n <= 1'b1;
		repeat (3) @(posedge clock);
		for (int k = 0; k < 9; k++) begin
			rate <= rows[k].r;
			bus(1'b1, ctrl_addr, {2'h0, rows[k].mx});
			bus(1'b1, mode_addr, {rows[k].mn, 1'h0, rows[k].s});
			frame(rows[k].ln, 8'h00, 1'b0, rows[k].a);
		end
		for (int k = 0; k < 4; k++) begin
			rate <= k[0] ? rate_424 : rate_212;
			bus(1'b1, ctrl_addr, {1'h0, k[1], 6'h00});
			chk(slot_bits === ((k == 3) ? 8'h40 : 8'h80), "slot");
		end
		bus(1'b1, settings_addr, 8'hb8);
		chk(sens === 3'h5 && tau === 2'h3, "decoder fields");
		bus(1'b1, ctrl_addr, 8'h00);
		bus(1'b1, mode_addr, 8'h00);
		for (int e = 0; e < 4; e++) begin
			bus(1'b1, settings_addr, {6'h18, e[1:0]});
			frame(9'h010, 8'h00, 1'b0, 1'b1);
			pulse(3);
			n = (7 + e) * (bit424_ns / clock_ns);
			wait_start(600);
			chk(got && t_start - t_done >= n - 1 && t_start - t_done <= n + 4,
				"response time");
			if (!got)
				conclude;
		end
		bit_phase_ok <= 1'b0;
		pulse(3);
		wait_start(10);
		chk(!got, "start without phase");
		// request held back by the phase: timer elapsed and request pending
		bus(1'b0, status_addr, 8'h00);
		chk(q === 32'h3, "status pending");
		bit_phase_ok <= 1'b1;
		wait_start(4);
		chk(got, "late start");
		rate <= rate_106;
		card_mode <= 1'b1;
		pulse(0);
		frame(9'h002, 8'h26, 1'b1, 1'b0);
		frame(9'h002, 8'h52, 1'b1, 1'b1);
		bus(1'b0, settings_addr, 8'h00);
		chk(q[halt_bit] === 1'b1, "halt set");
		pulse(1);
		frame(9'h002, 8'h26, 1'b1, 1'b1);
		bus(1'b0, settings_addr, 8'h00);
		chk(q[halt_bit] === 1'b0, "halt cleared");
		bus(1'b1, settings_addr, 8'h64);
		frame(9'h002, 8'h26, 1'b1, 1'b0);
		anticoll_active <= 1'b1;
		bus(1'b1, mode_addr, 8'h02);
		bus(1'b1, ctrl_addr, 8'h80);
		chk(active_mode_en === 1'b0, "active blocked");
		frame(9'h004, 8'h00, 1'b0, 1'b1);
		repeat (3) @(posedge clock);
		chk(n_end == 0, "early end");
		pulse(2);
		frame(9'h004, 8'h00, 1'b0, 1'b1);
		repeat (3) @(posedge clock);
		chk(n_end == 1, "end after select");
		anticoll_active <= 1'b0;
		bus(1'b1, ctrl_addr, 8'h00);
		chk(active_mode_en === 1'b1, "active allowed");
		bus(1'b1, ctrl_addr, 8'hff);
		rst_n <= 1'b0;
		repeat (10) @(posedge clock);
		rst_n <= 1'b1;
		repeat (3) @(posedge clock);
		bus(1'b0, settings_addr, 8'h00);
		chk(q === 32'h62 && sens === 3'h3 && tau === 2'h0, "reset");
		bus(1'b1, 10'h000, 8'hff);
		bus(1'b0, ctrl_addr, 8'h00);
		chk(q === 32'h0 && slot_bits === 8'h80, "ctrl reset");
		bus(1'b0, 10'h000, 8'h00);
		chk(q === 32'h0, "unmapped read");
		conclude;
	end
endmodule
